// ---- rtc_time_map.vh ----
// Purpose : constants for the time-of-day and day-count counters
// Assumes : included by bare name from each design file
// Notes   : register addresses are the byte addresses of the local register space
`ifndef RTC_TIME_MAP_VH
`define RTC_TIME_MAP_VH

// register addresses
`define ADDR_MINUTES      8'hfc
`define ADDR_HOURS        8'hfd
`define ADDR_DAY_LOW      8'hfe
`define ADDR_DAY_HIGH     8'hff

// field positions inside the hour and minute registers
`define HOUR_MSB          4
`define HOUR_LSB          0
`define WDAY_MSB          7
`define WDAY_LSB          5
`define MIN_MSB           5

// count limits
`define MIN_LAST          6'h3b
`define HOUR_LAST         5'h17
`define WDAY_FIRST        3'h1
`define WDAY_LAST         3'h7
`define WDAY_OFF          3'h0
`define DAY_LAST          8'hff

// reset values
`define RDATA_RESET       8'h00
`define PEND_RESET        4'h0

// pending-minute accumulator
`define PEND_W            4
`define PEND_MAX          4'hf

// access window timing
// 1.95 ms at 125 MHz, counted in 8 ns core cycles
`define WIN_LIMIT_CYC     18'd243750
`define WIN_CNT_W         18

`endif

// ---- rtc_access_window.v ----
// Purpose : read-enable and write-enable controls with automatic timeout
// Assumes : controls written by a one-cycle strobe on the core clock
// Notes   : the enables are cleared by reset; the counters they guard are not
`include "rtc_time_map.vh"

module rtc_access_window #(
  parameter [`WIN_CNT_W-1:0] TIMEOUT_CYC = `WIN_LIMIT_CYC
) (
  input  wire i_clk,
  input  wire i_rst_n,
  input  wire i_ctrl_wr,
  input  wire i_set_read,
  input  wire i_set_write,
  output wire o_read_en,
  output wire o_write_en,
  output wire o_timeout
);

  reg                  read_en_reg;
  reg                  read_en_next;
  reg                  write_en_reg;
  reg                  write_en_next;
  reg [`WIN_CNT_W-1:0] timer_reg;
  reg [`WIN_CNT_W-1:0] timer_next;
  reg                  timeout_reg;
  reg                  timeout_next;

  wire both_set = i_set_read & i_set_write;
  wire any_open = read_en_reg | write_en_reg;
  wire expired  = any_open & (timer_reg == TIMEOUT_CYC - 1'b1);
  // a set of an enable that is not yet open, and a request that leaves one open
  wire fresh_set = (i_set_read & ~read_en_reg) | (i_set_write & ~write_en_reg);
  wire keep_open = i_set_read | i_set_write;

  // next state: a write that tries to raise both enables is dropped whole
  always @* begin
    read_en_next  = read_en_reg;
    write_en_next = write_en_reg;
    timer_next    = timer_reg;
    timeout_next  = 1'b0;
    if (i_ctrl_wr && !both_set) begin
      read_en_next  = i_set_read;
      write_en_next = i_set_write;
      // a fresh set restarts the window; rewriting an open enable does not
      if (fresh_set) begin
        timer_next = {`WIN_CNT_W{1'b0}};
      end else if (expired && keep_open) begin
        // a rewrite must not stretch the window past its limit
        read_en_next  = 1'b0;
        write_en_next = 1'b0;
        timer_next    = {`WIN_CNT_W{1'b0}};
        timeout_next  = 1'b1;
      end else if (keep_open) begin
        timer_next = timer_reg + 1'b1;
      end
    end else if (expired) begin
      read_en_next  = 1'b0;
      write_en_next = 1'b0;
      timer_next    = {`WIN_CNT_W{1'b0}};
      timeout_next  = 1'b1;
    end else if (any_open) begin
      timer_next = timer_reg + 1'b1;
    end
  end

  // state flops
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_en_reg  <= 1'b0;
      write_en_reg <= 1'b0;
      timer_reg    <= {`WIN_CNT_W{1'b0}};
      timeout_reg  <= 1'b0;
    end else begin
      read_en_reg  <= read_en_next;
      write_en_reg <= write_en_next;
      timer_reg    <= timer_next;
      timeout_reg  <= timeout_next;
    end
  end

  assign o_read_en  = read_en_reg;
  assign o_write_en = write_en_reg;
  assign o_timeout  = timeout_reg;

endmodule

// ---- rtc_time_counters.v ----
// Purpose : minutes, hours, weekday and 16-bit day count of the real-time clock
// Assumes : register bus and minute tick are on I_CORE_CLK; tick is one cycle wide
// Notes   : time counters carry no reset and keep their value over ordinary resets
//
// What this block does
// - bits 7 and 6 of the minutes register read as zero and ignore writes.
// - minutes count in binary from 0 to 59 and wrap to 0.
// - software reads the time registers only while read enable is set.
// - writes to the time registers take effect only while write enable is set.
// - hours sit in bits 4..0 and count 0 to 23, wrapping to 0.
// - the weekday in bits 7..5 cycles 1 to 7 and steps when hours wrap.
// - a weekday written as zero stays zero until a nonzero value is written.
// - weekday and day count take no part in alarm matching.
// - the day count is 16 bits, low byte and high byte in two registers.
// - a rollover of the high day byte clears both day bytes.
// - while read enable is set the visible counters hold, and time is kept.
// - an enable opens the window and clears itself after 1.95 ms.
// - setting both enables at once is ignored; software waits before a new set.
`include "rtc_time_map.vh"

module rtc_time_counters #(
  parameter [`WIN_CNT_W-1:0] WIN_TIMEOUT_CYC = `WIN_LIMIT_CYC
) (
  input  wire       I_CORE_CLK,
  input  wire       I_NRST,
  input  wire [7:0] I_SFR_ADDR,
  input  wire       I_SFR_WR,
  input  wire       I_SFR_RD,
  input  wire [7:0] I_SFR_WDATA,
  output wire [7:0] O_SFR_RDATA,
  output wire       O_SFR_HIT,
  input  wire       I_CTRL_WR,
  input  wire       I_CTRL_READ_EN,
  input  wire       I_CTRL_WRITE_EN,
  output wire       O_TIME_READ_ENABLE,
  output wire       O_TIME_WRITE_ENABLE,
  output wire       O_WINDOW_TIMEOUT,
  input  wire       I_MINUTE_TICK,
  output wire       O_TICK_PENDING,
  output wire       O_DAY_ROLLOVER
);

  // reset release: asynchronous assert, two-flop synchronous release
  reg  rst_meta_reg;
  reg  rst_sync_reg;
  wire rst_n = rst_sync_reg;

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // read and write windows with their timeout
  wire time_read_enable;
  wire time_write_enable;
  wire window_timeout;

  rtc_access_window #(
    .TIMEOUT_CYC (WIN_TIMEOUT_CYC)
  ) u_window (
    .i_clk       (I_CORE_CLK),
    .i_rst_n     (rst_n),
    .i_ctrl_wr   (I_CTRL_WR),
    .i_set_read  (I_CTRL_READ_EN),
    .i_set_write (I_CTRL_WRITE_EN),
    .o_read_en   (time_read_enable),
    .o_write_en  (time_write_enable),
    .o_timeout   (window_timeout)
  );

  // counters: no reset, their contents survive ordinary resets
  reg [5:0]         minutes_reg;
  reg [5:0]         minutes_next;
  reg [4:0]         hours_reg;
  reg [4:0]         hours_next;
  reg [2:0]         weekday_field_reg;
  reg [2:0]         weekday_field_next;
  reg [7:0]         day_count_low_reg;
  reg [7:0]         day_count_low_next;
  reg [7:0]         day_count_high_reg;
  reg [7:0]         day_count_high_next;

  // control and status flops
  reg [`PEND_W-1:0] pending_reg;
  reg [`PEND_W-1:0] pending_next;
  reg [7:0]         rdata_reg;
  reg [7:0]         rdata_next;
  reg               hit_reg;
  reg               hit_next;
  reg               rollover_reg;
  reg               rollover_next;

  // address decode
  wire sel_minutes = (I_SFR_ADDR == `ADDR_MINUTES);
  wire sel_hours   = (I_SFR_ADDR == `ADDR_HOURS);
  wire sel_day_low = (I_SFR_ADDR == `ADDR_DAY_LOW);
  wire sel_day_hi  = (I_SFR_ADDR == `ADDR_DAY_HIGH);
  wire sel_any     = sel_minutes | sel_hours | sel_day_low | sel_day_hi;

  // a write lands only inside the write window
  wire wr_ok = I_SFR_WR & sel_any & time_write_enable;

  // counting halts while either window is open; ticks are banked meanwhile
  wire frozen     = time_read_enable | time_write_enable;
  wire apply_tick = !frozen && (pending_reg != `PEND_RESET);

  // carry chain; the alarm logic sees none of the weekday or day bytes
  wire min_wrap   = apply_tick && (minutes_reg == `MIN_LAST);
  wire hour_wrap  = min_wrap && (hours_reg == `HOUR_LAST);
  wire dlow_wrap  = hour_wrap && (day_count_low_reg == `DAY_LAST);
  wire dhigh_wrap = dlow_wrap && (day_count_high_reg == `DAY_LAST);

  // pending minute ticks: a tick and a drain in one cycle cancel out
  always @* begin
    pending_next = pending_reg;
    if (I_MINUTE_TICK && !apply_tick) begin
      // saturates: more than fifteen minutes frozen loses time, a usage limit
      if (pending_reg != `PEND_MAX) begin
        pending_next = pending_reg + 1'b1;
      end
    end else if (!I_MINUTE_TICK && apply_tick) begin
      pending_next = pending_reg - 1'b1;
    end
  end

  // minutes: software write has priority, but ticks never land in a window
  always @* begin
    minutes_next = minutes_reg;
    if (wr_ok && sel_minutes) begin
      minutes_next = I_SFR_WDATA[`MIN_MSB:0];
    end else if (apply_tick) begin
      if (min_wrap) begin
        minutes_next = 6'h00;
      end else begin
        minutes_next = minutes_reg + 1'b1;
      end
    end
  end

  // hours and weekday share one register
  always @* begin
    hours_next         = hours_reg;
    weekday_field_next = weekday_field_reg;
    if (wr_ok && sel_hours) begin
      hours_next         = I_SFR_WDATA[`HOUR_MSB:`HOUR_LSB];
      weekday_field_next = I_SFR_WDATA[`WDAY_MSB:`WDAY_LSB];
    end else if (min_wrap) begin
      if (hour_wrap) begin
        hours_next = 5'h00;
        // a zero weekday means the function is off and it stays there
        if (weekday_field_reg == `WDAY_OFF) begin
          weekday_field_next = `WDAY_OFF;
        end else if (weekday_field_reg == `WDAY_LAST) begin
          weekday_field_next = `WDAY_FIRST;
        end else begin
          weekday_field_next = weekday_field_reg + 1'b1;
        end
      end else begin
        hours_next = hours_reg + 1'b1;
      end
    end
  end

  // day count: low byte, then high byte; a high rollover clears both
  always @* begin
    day_count_low_next  = day_count_low_reg;
    day_count_high_next = day_count_high_reg;
    if (wr_ok && sel_day_low) begin
      day_count_low_next = I_SFR_WDATA;
    end else if (wr_ok && sel_day_hi) begin
      day_count_high_next = I_SFR_WDATA;
    end else if (dhigh_wrap) begin
      day_count_low_next  = 8'h00;
      day_count_high_next = 8'h00;
    end else if (dlow_wrap) begin
      day_count_low_next  = 8'h00;
      day_count_high_next = day_count_high_reg + 1'b1;
    end else if (hour_wrap) begin
      day_count_low_next = day_count_low_reg + 1'b1;
    end
  end

  // counter flops: deliberately without reset so time survives a reset
  always @(posedge I_CORE_CLK) begin
    minutes_reg        <= minutes_next;
    hours_reg          <= hours_next;
    weekday_field_reg  <= weekday_field_next;
    day_count_low_reg  <= day_count_low_next;
    day_count_high_reg <= day_count_high_next;
  end

  // read return: the frozen snapshot, or zero outside the read window
  always @* begin
    rdata_next = rdata_reg;
    hit_next   = 1'b0;
    if (I_SFR_RD && sel_any) begin
      hit_next = 1'b1;
      if (!time_read_enable) begin
        rdata_next = `RDATA_RESET;
      end else if (sel_minutes) begin
        rdata_next = {2'b00, minutes_reg};
      end else if (sel_hours) begin
        rdata_next = {weekday_field_reg, hours_reg};
      end else if (sel_day_low) begin
        rdata_next = day_count_low_reg;
      end else begin
        rdata_next = day_count_high_reg;
      end
    end else if (I_SFR_WR && sel_any) begin
      hit_next = 1'b1;
    end
  end

  // status flops
  always @* begin
    rollover_next = dhigh_wrap;
  end

  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg  <= `PEND_RESET;
      rdata_reg    <= `RDATA_RESET;
      hit_reg      <= 1'b0;
      rollover_reg <= 1'b0;
    end else begin
      pending_reg  <= pending_next;
      rdata_reg    <= rdata_next;
      hit_reg      <= hit_next;
      rollover_reg <= rollover_next;
    end
  end

  assign O_SFR_RDATA         = rdata_reg;
  assign O_SFR_HIT           = hit_reg;
  assign O_TIME_READ_ENABLE  = time_read_enable;
  assign O_TIME_WRITE_ENABLE = time_write_enable;
  assign O_WINDOW_TIMEOUT    = window_timeout;
  assign O_TICK_PENDING      = (pending_reg != `PEND_RESET);
  assign O_DAY_ROLLOVER      = rollover_reg;

endmodule

// ---- rtc_time_counters_checker.sv ----
// Purpose: port-level checks of the time counters and access windows
// Assumes: one core clock domain, reset low on I_NRST
// Notes: counters of open cycles catch a timer that never expires
module rtc_time_counters_checker #(
  parameter [17:0] WIN_TIMEOUT_CYC = 18'd100
) (
  input wire       I_CORE_CLK,
  input wire       I_NRST,
  input wire [7:0] I_SFR_ADDR,
  input wire       I_SFR_WR,
  input wire       I_SFR_RD,
  input wire [7:0] I_SFR_WDATA,
  input wire [7:0] O_SFR_RDATA,
  input wire       O_SFR_HIT,
  input wire       I_CTRL_WR,
  input wire       I_CTRL_READ_EN,
  input wire       I_CTRL_WRITE_EN,
  input wire       O_TIME_READ_ENABLE,
  input wire       O_TIME_WRITE_ENABLE,
  input wire       O_WINDOW_TIMEOUT,
  input wire       I_MINUTE_TICK,
  input wire       O_TICK_PENDING,
  input wire       O_DAY_ROLLOVER
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  wire       acc  = (I_SFR_RD | I_SFR_WR) & (I_SFR_ADDR[7:2] == 6'h3f);
  wire       both = I_CTRL_WR & I_CTRL_READ_EN & I_CTRL_WRITE_EN;
  reg [17:0] cr_reg;
  reg [17:0] cw_reg;
  // length of each open window so far; held for one cycle after it closes, then cleared
  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cr_reg <= 18'h0;
      cw_reg <= 18'h0;
    end else begin
      cr_reg <= O_TIME_READ_ENABLE ? cr_reg + 18'h1 : 18'h0;
      cw_reg <= O_TIME_WRITE_ENABLE ? cw_reg + 18'h1 : 18'h0;
    end
  end
  chk_hit_pulse: assert property (acc |=> O_SFR_HIT) else $error("hit missing");
  chk_no_hit: assert property (!acc |=> !O_SFR_HIT) else $error("stray hit");
  chk_min_upper: assert property ((I_SFR_RD && I_SFR_ADDR == 8'hfc) |=>
    O_SFR_RDATA[7:6] == 2'b00) else $error("minute upper bits set");
  chk_read_closed: assert property ((I_SFR_RD && acc && !O_TIME_READ_ENABLE) |=>
    O_SFR_RDATA == 8'h00) else $error("closed read not zero");
  chk_both_ignored: assert property (both |=> O_WINDOW_TIMEOUT ||
    ($stable(O_TIME_READ_ENABLE) && $stable(O_TIME_WRITE_ENABLE))) else $error("both set taken");
  chk_ctrl_load: assert property ((I_CTRL_WR && !both) |=> O_WINDOW_TIMEOUT ||
    O_TIME_WRITE_ENABLE == $past(I_CTRL_WRITE_EN)) else $error("write enable not loaded");
  chk_one_window: assert property (!(O_TIME_READ_ENABLE && O_TIME_WRITE_ENABLE))
    else $error("both windows open");
  chk_window_len: assert property (cr_reg <= WIN_TIMEOUT_CYC && cw_reg <= WIN_TIMEOUT_CYC)
    else $error("window open too long");
  chk_timeout_cause: assert property (O_WINDOW_TIMEOUT |->
    (cr_reg == WIN_TIMEOUT_CYC || cw_reg == WIN_TIMEOUT_CYC)) else $error("timeout early");
  chk_tick_bank: assert property (I_MINUTE_TICK |=> O_TICK_PENDING) else $error("tick lost");
  cov_timeout: cover property (O_WINDOW_TIMEOUT);
  cov_rollover: cover property (O_DAY_ROLLOVER);
  cov_both_set: cover property (both);
endmodule
bind rtc_time_counters rtc_time_counters_checker #(.WIN_TIMEOUT_CYC(WIN_TIMEOUT_CYC)) u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR),
  .I_SFR_RD(I_SFR_RD), .I_SFR_WDATA(I_SFR_WDATA), .O_SFR_RDATA(O_SFR_RDATA),
  .O_SFR_HIT(O_SFR_HIT), .I_CTRL_WR(I_CTRL_WR), .I_CTRL_READ_EN(I_CTRL_READ_EN),
  .I_CTRL_WRITE_EN(I_CTRL_WRITE_EN), .O_TIME_READ_ENABLE(O_TIME_READ_ENABLE),
  .O_TIME_WRITE_ENABLE(O_TIME_WRITE_ENABLE), .O_WINDOW_TIMEOUT(O_WINDOW_TIMEOUT),
  .I_MINUTE_TICK(I_MINUTE_TICK), .O_TICK_PENDING(O_TICK_PENDING),
  .O_DAY_ROLLOVER(O_DAY_ROLLOVER));

// ---- rtc_time_counters_tb.sv ----
// Purpose: self-checking bench for the time counters
// Assumes: short window parameter so timeouts stay cheap
// Notes: a bench model of the counters predicts every read-window readback; closed reads expect zero
module rtc_time_counters_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [17:0] WIN = 18'd100;
  reg        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  reg        cwr = 1'b0, cre = 1'b0, cwe = 1'b0, tick = 1'b0;
  reg  [7:0] addr = 8'h00, wdata = 8'h00, dl, dh;
  wire [7:0] rdata;
  wire       ren, wen, roll;
  integer    seed = 32'h68ef, n_fail = 0, checks_done = 0, i;
  reg  [5:0] m;
  reg  [4:0] h;
  reg  [2:0] w;
  reg        exp_roll, roll_seen;
  rtc_time_counters #(.WIN_TIMEOUT_CYC(WIN)) dut (.I_CORE_CLK(clk), .I_NRST(nrst),
    .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_RD(rd), .I_SFR_WDATA(wdata),
    .O_SFR_RDATA(rdata), .O_SFR_HIT(), .I_CTRL_WR(cwr), .I_CTRL_READ_EN(cre),
    .I_CTRL_WRITE_EN(cwe), .O_TIME_READ_ENABLE(ren), .O_TIME_WRITE_ENABLE(wen),
    .O_WINDOW_TIMEOUT(), .I_MINUTE_TICK(tick), .O_TICK_PENDING(), .O_DAY_ROLLOVER(roll));
  initial forever #4 clk = ~clk;
  // remember a rollover pulse, it lasts a single cycle
  always @(posedge clk) if (roll === 1'b1) roll_seen <= 1'b1;
  task chk(input [7:0] got, input [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // spacing after each control write leaves room for up to 15 banked ticks to drain
  task ctrl(input r, input we);
    @(posedge clk); cwr <= 1'b1; cre <= r; cwe <= we;
    @(posedge clk); cwr <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  task acc(input is_wr, input [7:0] a, input [7:0] d);
    @(posedge clk); wr <= is_wr; rd <= !is_wr; addr <= a; wdata <= d;
    @(posedge clk); wr <= 1'b0; rd <= 1'b0;
    @(negedge clk);
  endtask
  task pulse_tick;
    @(posedge clk); tick <= 1'b1;
    @(posedge clk); tick <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // bench model of one minute step with all carries
  task adv;
    if (m != 6'h3b) m = m + 6'h1;
    else begin
      m = 6'h0;
      if (h != 5'h17) h = h + 5'h1;
      else begin
        h = 5'h0;
        if (w != 3'h0) w = (w == 3'h7) ? 3'h1 : w + 3'h1;
        if (dl != 8'hff) dl = dl + 8'h1;
        else begin
          dl = 8'h0;
          if (dh != 8'hff) dh = dh + 8'h1;
          else begin
            dh = 8'h0;
            exp_roll = 1'b1;
          end
        end
      end
    end
  endtask
  task run_case(input [5:0] cm, input [4:0] ch, input [2:0] cw, input [7:0] cl,
                input [7:0] chh, input integer k);
    m = cm; h = ch; w = cw; dl = cl; dh = chh; exp_roll = 1'b0; roll_seen = 1'b0;
    ctrl(1'b0, 1'b1);
    acc(1'b1, 8'hfc, {2'b11, m});
    acc(1'b1, 8'hfd, {w, h});
    acc(1'b1, 8'hfe, dl);
    acc(1'b1, 8'hff, dh);
    ctrl(1'b0, 1'b0);
    acc(1'b1, 8'hfc, 8'h2a);
    acc(1'b0, 8'hfc, 8'h00); chk(rdata, 8'h00);
    repeat (k) begin
      pulse_tick;
      adv;
    end
    ctrl(1'b1, 1'b0);
    pulse_tick;
    acc(1'b0, 8'hfc, 8'h00); chk(rdata, {2'b00, m});
    acc(1'b0, 8'hfd, 8'h00); chk(rdata, {w, h});
    acc(1'b0, 8'hfe, 8'h00); chk(rdata, dl);
    acc(1'b0, 8'hff, 8'h00); chk(rdata, dh);
    chk({7'h0, roll_seen}, {7'h0, exp_roll});
    ctrl(1'b0, 1'b0);
    adv;
    ctrl(1'b1, 1'b0);
    acc(1'b0, 8'hfc, 8'h00); chk(rdata, {2'b00, m});
    ctrl(1'b0, 1'b0);
    $display("case done: minute %h hour %h", cm, ch);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    run_case(6'h3b, 5'h17, 3'h7, 8'hff, 8'hff, 1);
    run_case(6'h3b, 5'h17, 3'h0, 8'h12, 8'h34, 1);
    run_case(6'h3b, 5'h17, 3'h3, 8'hff, 8'h07, 2);
    for (i = 0; i < 8; i = i + 1)
      run_case(6'({$random(seed)} % 60), 5'({$random(seed)} % 24), 3'($random(seed)),
               8'($random(seed)), 8'($random(seed)), 1 + {$random(seed)} % 3);
    // a mid-run reset clears the windows but must leave the time untouched
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, ren}, 8'h00);
    ctrl(1'b1, 1'b0);
    acc(1'b0, 8'hfc, 8'h00);
    chk(rdata, {2'b00, m});
    acc(1'b0, 8'hff, 8'h00);
    chk(rdata, dh);
    ctrl(1'b0, 1'b0);
    $display("reset hold done");
    ctrl(1'b0, 1'b1);
    chk({7'h0, wen}, 8'h01);
    repeat (WIN) @(posedge clk);
    chk({7'h0, wen}, 8'h00);
    $display("window timeout done");
    ctrl(1'b1, 1'b0);
    ctrl(1'b1, 1'b1);
    chk({7'h0, ren}, 8'h01);
    ctrl(1'b0, 1'b0);
    $display("both enables done");
    test_done;
  end
endmodule
